// [verilog/kbf_front_panel.sv]
// Front-panel keyboard glue: APB side for the system CPU, local
// decoder and latches for the keyboard processor, two knob latches.
// Assumes the keyboard processor and knobs are asynchronous pins.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "kbf_cfg.svh"
module kbf_front_panel
  import kbf_pkg::*;
#(
  parameter int ACK_TIMEOUT_CYC = `KBF_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  // APB slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [`KBF_APB_AW-1:0]    paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // CPU side strobes
  output logic                           transfer_ack_n_o,
  output logic                           outreg_drive_n_o,
  output logic                           kbd_irq_n_o,
  // Keyboard processor local bus
  input  wire logic                      local_addr_strobe_i,
  input  wire logic [4:0]                local_upper_addr_i,
  input  wire logic                      local_data_strobe_i,
  input  wire logic                      local_read_write_i,
  input  wire logic [7:0]                local_data_bus_i,
  output logic      [7:0]                local_data_bus_o,
  output logic                           local_data_bus_oe_o,
  input  wire logic [7:0]                proc_port_out_i,
  input  wire logic                      key_pressed_i,
  output logic                           kbd_select_n_o,
  // Instruction memory
  input  wire logic [7:0]                instr_rom_lines_i,
  output logic                           instr_rom_sel_n_o,
  output logic      [7:0]                instr_data_o,
  // Decoder strobes
  output logic                           clear_rotation_n_o,
  output logic                           kbd_ack_n_o,
  output logic                           led_bank1_load_n_o,
  output logic                           led_bank2_load_n_o,
  output logic                           outreg_load_n_o,
  // Indicators
  output logic                           x_cursor_n_o,
  output logic                           y_cursor_n_o,
  output logic                           param_enable_n_o,
  output logic      [7:0]                led_bank2_o,
  // Knobs
  input  wire logic                      marker_phase_a_i,
  input  wire logic                      marker_phase_b_i,
  input  wire logic                      param_phase_a_i,
  input  wire logic                      param_phase_b_i,
  output logic                           marker_turn_o,
  output logic                           marker_direction_o,
  output logic                           parameter_turn_o,
  output logic                           parameter_direction_o
);
  localparam int SYNC_W = 37;
  localparam logic [15:0] TMO_LAST = 16'(ACK_TIMEOUT_CYC - 1);

  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Pin synchronisers
  logic [SYNC_W-1:0] sync_s;
  logic [7:0]        rom_s;
  logic [7:0]        port_s;
  logic [7:0]        ldata_s;
  logic [4:0]        laddr_s;
  logic              las_s, lds_s, rw_s, keyp_s;
  logic              ma_s, mb_s, pa_s, pb_s;

  kbf_sync3 #(
    .W (SYNC_W)
  ) u_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .d_i     ({instr_rom_lines_i, proc_port_out_i, local_data_bus_i, local_upper_addr_i,
                local_addr_strobe_i, local_data_strobe_i, local_read_write_i,
                key_pressed_i, marker_phase_a_i, marker_phase_b_i,
                param_phase_a_i, param_phase_b_i}),
    .q_o     (sync_s)
  );

  assign {rom_s, port_s, ldata_s, laddr_s, las_s, lds_s, rw_s, keyp_s,
          ma_s, mb_s, pa_s, pb_s} = sync_s;

  // State
  kbf_apb_state_t st_q;
  kbf_apb_state_t st_d;
  logic [7:0]     cmd_q;
  logic [7:0]     cmd_d;
  logic [7:0]     ledin_q;
  logic [7:0]     ledin_d;
  logic           ksel_q;
  logic           ksel_d;
  logic [15:0]    tmo_q;
  logic [15:0]    tmo_d;
  kbf_led1_t      led1_q;
  kbf_led1_t      led1_d;
  logic [7:0]     led2_q;
  logic [7:0]     led2_d;
  logic [7:0]     outreg_q;
  logic [7:0]     outreg_d;
  logic           irq_q;
  logic           irq_d;
  logic [6:0]     keycode_q;
  logic [6:0]     keycode_d;
  logic           lds_prev_q;
  logic           p7_prev_q;
  logic           key_prev_q;
  logic [7:0]     ldout_q;
  logic [7:0]     ldout_d;
  logic [7:0]     instr_q;
  logic [7:0]     instr_d;

  // Decoder and event terms
  logic     acc, cmd_hit, oreg_hit;
  logic     wr_evt, clr_evt, ack_evt;
  logic     led1_evt, led2_evt, oreg_evt;
  logic     rom_sel, rd_sel, p7_rise, key_rise;
  logic     apb_ready, apb_err, xfer_ack;
  kbf_rot_t rot;

  always_comb begin
    acc      = psel_i & penable_i;
    cmd_hit  = (paddr_i == `KBF_OFS_CMD);
    oreg_hit = (paddr_i == `KBF_OFS_OUTREG);
    // Decodes count only while the address strobe is up
    wr_evt   = las_s & lds_s & ~lds_prev_q & ~rw_s;
    clr_evt  = wr_evt & (laddr_s == `KBF_LA_CLR);
    ack_evt  = wr_evt & (laddr_s == `KBF_LA_ACK);
    led1_evt = wr_evt & (laddr_s == `KBF_LA_LED1);
    led2_evt = wr_evt & (laddr_s == `KBF_LA_LED2);
    oreg_evt = wr_evt & (laddr_s == `KBF_LA_OREG);
    rom_sel  = las_s & rw_s & (laddr_s == `KBF_LA_ROM);
    rd_sel   = las_s & lds_s & rw_s &
               ((laddr_s == `KBF_LA_CMD) | (laddr_s == `KBF_LA_LEDDATA) |
                (laddr_s == `KBF_LA_ROT));
    p7_rise  = port_s[7] & ~p7_prev_q;
    key_rise = keyp_s & ~key_prev_q;
  end

  always_comb begin
    st_d      = st_q;
    cmd_d     = cmd_q;
    ledin_d   = ledin_q;
    ksel_d    = ksel_q;
    tmo_d     = tmo_q;
    led1_d    = led1_q;
    led2_d    = led2_q;
    outreg_d  = outreg_q;
    irq_d     = irq_q;
    keycode_d = keycode_q;
    apb_ready = 1'b1;
    apb_err   = 1'b0;
    xfer_ack  = 1'b0;
    instr_d   = rom_sel ? rom_s : `KBF_BYTE_RST;
    case (laddr_s)
      `KBF_LA_CMD:     ldout_d = cmd_q;
      `KBF_LA_LEDDATA: ldout_d = ledin_q;
      `KBF_LA_ROT:     ldout_d = {4'h0, rot};
      default:         ldout_d = `KBF_BYTE_RST;
    endcase
    case (st_q)
      KBF_IDLE: begin
        if (acc && cmd_hit && pwrite_i) begin
          cmd_d     = pwdata_i[`KBF_CMD_LSB +: 8];
          ledin_d   = pwdata_i[`KBF_LEDIN_LSB +: 8];
          ksel_d    = 1'b1;
          tmo_d     = '0;
          st_d      = KBF_WAIT;
          apb_ready = 1'b0;
        end
      end
      KBF_WAIT: begin
        apb_ready = 1'b0;
        tmo_d     = tmo_q + 16'h0001;
        // Timeout keeps a hung keyboard processor from freezing the bus
        if (ack_evt || tmo_q == TMO_LAST) begin
          apb_ready = 1'b1;
          apb_err   = ~ack_evt;
          xfer_ack  = ack_evt;
          ksel_d    = 1'b0;
          st_d      = KBF_IDLE;
        end
      end
      default: begin
        st_d = KBF_IDLE;
      end
    endcase
    if (led1_evt) begin
      led1_d = kbf_led1_t'(ledin_q);
    end
    if (led2_evt) begin
      led2_d = ledin_q;
    end
    if (oreg_evt) begin
      outreg_d = ldata_s;
    end
    if (key_rise) begin
      keycode_d = port_s[6:0];
    end
    // Set wins so an interrupt arriving with the clear is kept
    if (p7_rise || key_rise) begin
      irq_d = 1'b1;
    end else if (clr_evt) begin
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= KBF_IDLE;
      cmd_q      <= `KBF_BYTE_RST;
      ledin_q    <= `KBF_BYTE_RST;
      ksel_q     <= 1'b0;
      tmo_q      <= '0;
      led1_q     <= kbf_led1_t'(`KBF_BYTE_RST);
      led2_q     <= `KBF_BYTE_RST;
      outreg_q   <= `KBF_BYTE_RST;
      irq_q      <= 1'b0;
      keycode_q  <= '0;
      lds_prev_q <= 1'b0;
      p7_prev_q  <= 1'b0;
      key_prev_q <= 1'b0;
      ldout_q    <= `KBF_BYTE_RST;
      instr_q    <= `KBF_BYTE_RST;
    end else begin
      st_q       <= st_d;
      cmd_q      <= cmd_d;
      ledin_q    <= ledin_d;
      ksel_q     <= ksel_d;
      tmo_q      <= tmo_d;
      led1_q     <= led1_d;
      led2_q     <= led2_d;
      outreg_q   <= outreg_d;
      irq_q      <= irq_d;
      keycode_q  <= keycode_d;
      lds_prev_q <= lds_s;
      p7_prev_q  <= port_s[7];
      key_prev_q <= keyp_s;
      ldout_q    <= ldout_d;
      instr_q    <= instr_d;
    end
  end

  // Knob latches
  kbf_rpg_latch u_marker (
    .clk_i     (sys_clk_i),
    .rst_n_i   (rst_n),
    .armed_i   (led1_q.x_cur | led1_q.y_cur),
    .clear_i   (clr_evt),
    .phase_a_i (ma_s),
    .phase_b_i (mb_s),
    .turn_o    (rot.mturn),
    .dir_o     (rot.mdir)
  );

  kbf_rpg_latch u_param (
    .clk_i     (sys_clk_i),
    .rst_n_i   (rst_n),
    .armed_i   (led1_q.param_en),
    .clear_i   (clr_evt),
    .phase_a_i (pa_s),
    .phase_b_i (pb_s),
    .turn_o    (rot.pturn),
    .dir_o     (rot.pdir)
  );

  // APB read mux; output register only reaches the bus while driven
  always_comb begin
    outreg_drive_n_o = ~(acc & oreg_hit & ~pwrite_i);
    prdata_o         = 32'h0000_0000;
    pslverr_o        = 1'b0;
    if (acc && !pwrite_i) begin
      case (paddr_i)
        `KBF_OFS_CMD:     prdata_o = {16'h0000, ledin_q, cmd_q};
        `KBF_OFS_OUTREG:  prdata_o = {24'h00_0000,
                                      outreg_drive_n_o ? 8'h00 : outreg_q};
        `KBF_OFS_LEDS:    prdata_o = {16'h0000, led2_q, led1_q};
        `KBF_OFS_ROT:     prdata_o = {23'h00_0000, irq_q, 4'h0, rot};
        `KBF_OFS_KEYCODE: prdata_o = {25'h000_0000, keycode_q};
        default:          pslverr_o = 1'b1;
      endcase
    end else if (acc) begin
      pslverr_o = ~cmd_hit | apb_err;
    end
  end

  assign pready_o              = apb_ready;
  assign transfer_ack_n_o      = ~xfer_ack;
  assign kbd_irq_n_o           = ~irq_q;
  assign kbd_select_n_o        = ~ksel_q;
  assign local_data_bus_o      = ldout_q;
  assign local_data_bus_oe_o   = rd_sel;
  assign instr_rom_sel_n_o     = ~rom_sel;
  assign instr_data_o          = instr_q;
  assign clear_rotation_n_o    = ~clr_evt;
  assign kbd_ack_n_o           = ~ack_evt;
  assign led_bank1_load_n_o    = ~led1_evt;
  assign led_bank2_load_n_o    = ~led2_evt;
  assign outreg_load_n_o       = ~oreg_evt;
  assign x_cursor_n_o          = ~led1_q.x_cur;
  assign y_cursor_n_o          = ~led1_q.y_cur;
  assign param_enable_n_o      = ~led1_q.param_en;
  assign led_bank2_o           = led2_q;
  assign marker_turn_o         = rot.mturn;
  assign marker_direction_o    = rot.mdir;
  assign parameter_turn_o      = rot.pturn;
  assign parameter_direction_o = rot.pdir;

  AST_IRQ_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (clr_evt && !p7_rise && !key_rise) |=> kbd_irq_n_o)
    else $error("interrupt latch survived clear");
  AST_IRQ_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    p7_rise |=> !kbd_irq_n_o)
    else $error("port bit seven did not raise interrupt");
  AST_KEYCODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    key_rise |=> (keycode_q == $past(port_s[6:0])) && !kbd_irq_n_o)
    else $error("key code not captured");
  AST_KSEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (st_q == KBF_IDLE && acc && cmd_hit && pwrite_i) |-> !pready_o ##1 !kbd_select_n_o)
    else $error("command write did not select keyboard");
  AST_ACK_DONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (st_q == KBF_WAIT && ack_evt) |-> (pready_o && !transfer_ack_n_o) ##1 kbd_select_n_o)
    else $error("keyboard ack did not complete transfer");
  AST_LED1: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    led1_evt |=> (led1_q == $past(ledin_q)))
    else $error("bank one not loaded");
  AST_LED2: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    led2_evt |=> (led_bank2_o == $past(ledin_q)))
    else $error("bank two not loaded");
  AST_OREG_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    oreg_evt |=> (outreg_q == $past(ldata_s)))
    else $error("output register not loaded");
  AST_OREG_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (acc && oreg_hit && !pwrite_i) |-> !outreg_drive_n_o && (prdata_o[7:0] == outreg_q))
    else $error("output register not driven");
  AST_ROM: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    rom_sel |-> !instr_rom_sel_n_o ##1 (instr_data_o == $past(rom_s)))
    else $error("instruction lines not passed");
  AST_RESET: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $rose(rst_n) |-> kbd_irq_n_o && x_cursor_n_o && param_enable_n_o && !marker_turn_o)
    else $error("latches not clear after reset");
endmodule

// [shared/kbf_cfg.svh]
// Constants for the front-panel keyboard glue: bus offsets, local
// decoder codes, reset values and the ack timeout.
// Assumes a 32-bit APB slave with an 8-bit byte address.
`ifndef KBF_CFG_SVH
`define KBF_CFG_SVH

// APB byte offsets
`define KBF_APB_AW          8
`define KBF_OFS_CMD         8'h00
`define KBF_OFS_OUTREG      8'h04
`define KBF_OFS_LEDS        8'h08
`define KBF_OFS_ROT         8'h0C
`define KBF_OFS_KEYCODE     8'h10

// Command register fields
`define KBF_CMD_LSB         0
`define KBF_LEDIN_LSB       8

// Local decoder codes on the upper local address
`define KBF_LA_ROM          5'h00
`define KBF_LA_CMD          5'h01
`define KBF_LA_LEDDATA      5'h02
`define KBF_LA_LED1         5'h03
`define KBF_LA_LED2         5'h04
`define KBF_LA_OREG         5'h05
`define KBF_LA_CLR          5'h06
`define KBF_LA_ACK          5'h07
`define KBF_LA_ROT          5'h08

// Reset values and timing
`define KBF_BYTE_RST        8'h00
`define KBF_ACK_TIMEOUT_CYC 1000

`endif

// [shared/kbf_pkg.sv]
// Types for the front-panel keyboard glue.
// Constants live in kbf_cfg.svh; this package holds only types.
package kbf_pkg;

  typedef enum logic [0:0] {
    KBF_IDLE,
    KBF_WAIT
  } kbf_apb_state_t;

  // LED bank one: cursors and parameter enable, active high here
  typedef struct packed {
    logic [4:0] spare;
    logic       param_en;
    logic       y_cur;
    logic       x_cur;
  } kbf_led1_t;

  // Rotation status as seen by the keyboard processor
  typedef struct packed {
    logic pdir;
    logic pturn;
    logic mdir;
    logic mturn;
  } kbf_rot_t;

endpackage

// [verilog/kbf_sync3.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes the inputs are asynchronous pins; output is clean in sys_clk_i.
`timescale 1ns/1ps
module kbf_sync3 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // A bit moves only once stages two and three agree
  always_comb begin
    out_d = (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= d_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign q_o = out_q;
endmodule

// [verilog/kbf_rpg_latch.sv]
// Turn latch and direction latch for one rotary pulse generator.
// Assumes phase inputs already synchronised to clk_i.
`timescale 1ns/1ps
module kbf_rpg_latch (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic armed_i,
  input  wire logic clear_i,
  // Knob phases
  input  wire logic phase_a_i,
  input  wire logic phase_b_i,
  // Latches
  output logic      turn_o,
  output logic      dir_o
);
  logic a_prev_q;
  logic turn_q;
  logic turn_d;
  logic dir_q;
  logic dir_d;
  logic step;

  always_comb begin
    step   = phase_a_i & ~a_prev_q & armed_i;
    turn_d = turn_q;
    dir_d  = dir_q;
    if (step) begin
      turn_d = 1'b1;
      dir_d  = phase_b_i;
    end else if (clear_i || !armed_i) begin
      // Set wins over clear so a step in the clear cycle survives
      turn_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_prev_q <= 1'b0;
      turn_q   <= 1'b0;
      dir_q    <= 1'b0;
    end else begin
      a_prev_q <= phase_a_i;
      turn_q   <= turn_d;
      dir_q    <= dir_d;
    end
  end

  assign turn_o = turn_q;
  assign dir_o  = dir_q;

  AST_TURN_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (phase_a_i && !a_prev_q && armed_i) |=> turn_o && (dir_o == $past(phase_b_i)))
    else $error("turn latch missed an armed step");
  AST_TURN_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (clear_i && !(phase_a_i && !a_prev_q && armed_i)) |=> !turn_o)
    else $error("turn latch not cleared");
  AST_DIR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(phase_a_i && !a_prev_q && armed_i) |=> $stable(dir_o))
    else $error("direction changed without a step");
  AST_DISARM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !armed_i [*2] |-> !turn_o)
    else $error("turn latch set while disarmed");
endmodule

// [tb/kbf_proc_model.sv]
// Keyboard processor model driving the local bus of the glue.
// Assumes the bench calls xfer only while no command is pending.
`timescale 1ns/1ps
`include "kbf_cfg.svh"
module kbf_proc_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       sel_n_i,
  input  wire logic [3:0] ack_dly_i,
  // Local bus
  output logic            as_o,
  output logic      [4:0] ua_o,
  output logic            ds_o,
  output logic            rw_o,
  output logic      [7:0] db_o
);
  task automatic xfer(input logic [4:0] a, input logic [7:0] d, input logic r);
    @(posedge clk_i);
    as_o <= 1'h1;
    ua_o <= a;
    rw_o <= r;
    db_o <= d;
    repeat (5) @(posedge clk_i);
    ds_o <= 1'h1;
    repeat (6) @(posedge clk_i);
    ds_o <= 1'h0;
    repeat (5) @(posedge clk_i);
    as_o <= 1'h0;
    // Released lines flip so stale values cannot match
    ua_o <= ~a;
    db_o <= ~d;
  endtask
  initial begin
    as_o = 1'h0;
    ua_o = 5'h1F;
    ds_o = 1'h0;
    rw_o = 1'h1;
    db_o = 8'hFF;
  end
  // Code F never answers, to force the ack timeout
  always @(posedge clk_i) begin
    if (sel_n_i === 1'h0 && ack_dly_i != 4'hF) begin
      repeat (ack_dly_i) @(posedge clk_i);
      xfer(`KBF_LA_ACK, 8'h00, 1'h0);
    end
  end
endmodule

// [tb/front_panel_keyboard_interface_test.sv]
// Self-checking bench for the front panel glue over APB and local bus.
// Assumes the processor model answers each command write but the last, which is left unanswered to check the ack timeout.
`timescale 1ns/1ps
`include "kbf_cfg.svh"
module front_panel_keyboard_interface_test;
  logic        sys_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        transfer_ack_n_o, outreg_drive_n_o, kbd_irq_n_o, local_data_bus_oe_o;
  logic        local_addr_strobe_i, local_data_strobe_i, local_read_write_i, key_pressed_i;
  logic        kbd_select_n_o, instr_rom_sel_n_o, x_cursor_n_o, y_cursor_n_o, param_enable_n_o;
  logic        marker_phase_a_i, marker_phase_b_i, param_phase_a_i, param_phase_b_i;
  logic        marker_turn_o, marker_direction_o, parameter_turn_o, parameter_direction_o;
  logic [4:0]  local_upper_addr_i;
  logic [7:0]  paddr_i, local_data_bus_i, local_data_bus_o, m_db, proc_port_out_i;
  logic [7:0]  instr_rom_lines_i, instr_data_o, led_bank2_o;
  logic [3:0]  ack_dly;
  logic [31:0] pwdata_i, prdata_o, rd, n_ack, sel_seen, drv_seen;
  logic        er;
  int          n_mismatch, check_count;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] r;
    logic        e;
  } kbf_row_t;
  localparam kbf_row_t ROWS [5] = '{
    '{1'h0, `KBF_OFS_LEDS, 32'h0, 1'h0}, '{1'h0, `KBF_OFS_ROT, 32'h0, 1'h0},
    '{1'h0, `KBF_OFS_KEYCODE, 32'h0, 1'h0}, '{1'h1, `KBF_OFS_LEDS, 32'h0, 1'h1},
    '{1'h0, 8'h14, 32'h0, 1'h1}};
  assign local_data_bus_i = local_data_bus_oe_o ? local_data_bus_o : m_db;
  kbf_front_panel #(.ACK_TIMEOUT_CYC(40)) i_kbf_front_panel (
    .sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .transfer_ack_n_o, .outreg_drive_n_o, .kbd_irq_n_o,
    .local_addr_strobe_i, .local_upper_addr_i, .local_data_strobe_i, .local_read_write_i,
    .local_data_bus_i, .local_data_bus_o, .local_data_bus_oe_o, .proc_port_out_i,
    .key_pressed_i, .kbd_select_n_o, .instr_rom_lines_i, .instr_rom_sel_n_o, .instr_data_o,
    .clear_rotation_n_o(), .kbd_ack_n_o(), .led_bank1_load_n_o(), .led_bank2_load_n_o(),
    .outreg_load_n_o(), .x_cursor_n_o, .y_cursor_n_o, .param_enable_n_o, .led_bank2_o,
    .marker_phase_a_i, .marker_phase_b_i, .param_phase_a_i, .param_phase_b_i,
    .marker_turn_o, .marker_direction_o, .parameter_turn_o, .parameter_direction_o);
  kbf_proc_model i_kbf_proc_model (
    .clk_i(sys_clk_i), .sel_n_i(kbd_select_n_o), .ack_dly_i(ack_dly),
    .as_o(local_addr_strobe_i), .ua_o(local_upper_addr_i), .ds_o(local_data_strobe_i),
    .rw_o(local_read_write_i), .db_o(m_db));
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (transfer_ack_n_o === 1'h0) n_ack <= n_ack + 1;
    if (kbd_select_n_o === 1'h0) sel_seen <= 1;
    if (outreg_drive_n_o === 1'h0) drv_seen <= 1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    do @(posedge sys_clk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic lw(input logic [4:0] a, input logic [7:0] d);
    i_kbf_proc_model.xfer(a, d, 1'h0);
    wt(8);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {sys_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, key_pressed_i} = '0;
    {marker_phase_a_i, marker_phase_b_i, param_phase_a_i, param_phase_b_i} = '0;
    {paddr_i, pwdata_i, proc_port_out_i, instr_rom_lines_i, n_ack, sel_seen, drv_seen} = '0;
    ack_dly = 4'h8;
    wt(5);
    reset_n_i <= 1'h1;
    wt(3);
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, 32'h0);
      chk("row data", ROWS[i].r, rd);
      chk("row error", ROWS[i].e, er);
    end
    apb(1'h1, `KBF_OFS_CMD, 32'h0000075A);
    chk("cmd error", 32'h0, er);
    chk("select seen", 32'h1, sel_seen);
    wt(20);
    chk("ack pulses", 32'h1, n_ack);
    chk("select released", 32'h1, kbd_select_n_o);
    lw(`KBF_LA_LED1, 8'h00);
    chk("cursors", 32'h0, {x_cursor_n_o, y_cursor_n_o, param_enable_n_o});
    lw(`KBF_LA_LED2, 8'h00);
    chk("bank two", 32'h07, led_bank2_o);
    marker_phase_b_i <= 1'h1;
    wt(6);
    marker_phase_a_i <= 1'h1;
    param_phase_a_i <= 1'h1;
    wt(8);
    chk("knobs", 32'h7, {parameter_direction_o, parameter_turn_o,
                         marker_direction_o, marker_turn_o});
    lw(`KBF_LA_CLR, 8'h00);
    chk("turn clear", 32'h0, {parameter_turn_o, marker_turn_o});
    lw(`KBF_LA_OREG, 8'hA5);
    apb(1'h0, `KBF_OFS_OUTREG, 32'h0);
    chk("outreg", 32'hA5, rd);
    wt(1);
    chk("drive seen", 32'h1, drv_seen);
    chk("drive idle", 32'h1, outreg_drive_n_o);
    proc_port_out_i <= 8'h23;
    wt(6);
    proc_port_out_i <= 8'hA3;
    key_pressed_i <= 1'h1;
    wt(8);
    chk("irq", 32'h0, kbd_irq_n_o);
    apb(1'h0, `KBF_OFS_ROT, 32'h0);
    chk("status", 32'h102, rd);
    apb(1'h0, `KBF_OFS_KEYCODE, 32'h0);
    chk("key code", 32'h23, rd);
    lw(`KBF_LA_CLR, 8'h00);
    chk("irq clear", 32'h1, kbd_irq_n_o);
    instr_rom_lines_i <= 8'h3C;
    fork
      i_kbf_proc_model.xfer(`KBF_LA_ROM, 8'h00, 1'h1);
      begin
        wt(12);
        chk("rom select", 32'h0, instr_rom_sel_n_o);
        chk("rom data", 32'h3C, instr_data_o);
      end
    join
    fork
      i_kbf_proc_model.xfer(`KBF_LA_CMD, 8'h00, 1'h1);
      begin
        wt(12);
        chk("local read", 32'h15A, {local_data_bus_oe_o, local_data_bus_o});
      end
    join
    chk("local release", 32'h0, local_data_bus_oe_o);
    ack_dly <= 4'hF;
    apb(1'h1, `KBF_OFS_CMD, 32'h00000011);
    chk("ack timeout", 32'h1, er);
    reset_n_i <= 1'h0;
    wt(2);
    chk("reset leds", 32'h7, {x_cursor_n_o, y_cursor_n_o, param_enable_n_o});
    chk("reset dirs", 32'h0, {marker_direction_o, marker_turn_o});
    end_of_test();
  end
endmodule
